// ### logic/twbc_pkg.sv
package twbc_pkg;

  // ---------------------------------------------------------------
  // register map (word index, byte address is four times it)
  // ---------------------------------------------------------------
  localparam logic [5:0] REG_CTRL  = 6'h00; // bus_control_reg
  localparam logic [5:0] REG_STAT  = 6'h01; // bus_status_reg
  localparam logic [5:0] REG_SHIFT = 6'h02; // shift_register
  localparam logic [5:0] REG_OWN   = 6'h03; // own_address_reg

  // write-one pulse bits of the control word
  localparam int CB_SPT  = 0;               // stop_request
  localparam int CB_STT  = 1;               // start_request
  localparam int CB_WREL = 5;               // wait_release

  // ---------------------------------------------------------------
  // carriers
  // ---------------------------------------------------------------
  typedef struct packed {
    logic en;                               // block enable
    logic rsv;                              // reads zero
    logic wrel;                             // pulse, stored as zero
    logic spie;                             // stop_interrupt_enable
    logic wtim;                             // wait_timing_select
    logic acke;                             // ack_enable
    logic stt;                              // pulse, stored as zero
    logic spt;                              // pulse, stored as zero
  } twbc_ctrl_t;

  typedef struct packed {
    logic wait_on;                          // clock held by a wait
    logic match;                            // own address received
    logic ext;                              // extension code received
    logic master;                           // master role active
    logic trc;                              // transmit_receive_flag
    logic ackd;                             // ack_detected
    logic std;                              // start_detected
    logic spd;                              // stop_detected
  } twbc_stat_t;

  // master sequencer states
  typedef enum logic [4:0] {
    M_IDLE  = 5'h01,
    M_START = 5'h02,
    M_RUN   = 5'h04,
    M_PRE   = 5'h08,
    M_RISE  = 5'h10
  } twbc_mst_t;

  // ---------------------------------------------------------------
  // reset values and counts
  // ---------------------------------------------------------------
  localparam twbc_ctrl_t CTRL_RST = 8'h00;
  localparam logic [7:0] SHIFT_RST = 8'h00;
  localparam logic [6:0] OWN_RST   = 7'h00;
  localparam logic       SPD_RST   = 1'b1;  // bus taken as free
  localparam logic [3:0] RC_ACK    = 4'h8;  // rises seen at 8th fall
  localparam logic [3:0] RC_LAST   = 4'h9;  // rises seen at 9th fall
  localparam logic [3:0] EXT_LO    = 4'h0;
  localparam logic [3:0] EXT_HI    = 4'hF;
  localparam int CLK_MHZ     = 125;
  localparam int SCL_HALF_NS = 5000;        // least half period
  localparam int SCL_HALF_CYC = (SCL_HALF_NS * CLK_MHZ + 999) / 1000;

endpackage

// ### logic/twbc_sync.sv
`timescale 1ns/1ns
module twbc_sync #(
  parameter int W = 2                       // number of lines
) (
  input  wire logic         hclk,           // system clock
  input  wire logic         hresetn,        // async reset, low
  input  wire logic [W-1:0] d_in,           // raw pin levels
  output logic      [W-1:0] lvl,            // synchronised level
  output logic      [W-1:0] rise,           // one-cycle rise pulse
  output logic      [W-1:0] fall            // one-cycle fall pulse
);

  // ---------------------------------------------------------------
  // two-stage synchroniser plus a history stage for edges
  // ---------------------------------------------------------------
  logic [W-1:0] s1_q;                       // metastable stage
  logic [W-1:0] s2_q;                       // stable stage
  logic [W-1:0] s3_q;                       // previous stable level

  // idle bus lines float high, so reset to ones
  always_ff @(posedge hclk or negedge hresetn)
    if (!hresetn)
    begin
      s1_q <= '1;
      s2_q <= '1;
      s3_q <= '1;
    end
    else
    begin
      s1_q <= d_in;
      s2_q <= s1_q;
      s3_q <= s2_q;
    end

  assign lvl  = s2_q;
  assign rise = s2_q & ~s3_q;
  assign fall = ~s2_q & s3_q;

endmodule // twbc_sync

// ### logic/twbc_top.sv
`timescale 1ns/1ns
// Function
// R1: start is data falling while clock high
// R2: start request after stop; flag starts
// R3: seven address bits follow the start
// R4: slave compares address, stays selected until condition
// R5: no interrupt for foreign non-extension address
// R6: address plus direction shifted as one byte
// R7: eighth bit zero write, one read
// R8: receiver pulls data low on ninth clock
// R9: acknowledge seen after sent byte is flagged
// R10: data acknowledge only while ack enable set
// R11: direction flag loaded from address eighth bit
// R12: clear ack enable to refuse further data
// R13: master ends with stop or restart
// R14: own address always acked, others not
// R15: extension code acked if enable preset
// R16: ack driven from eighth fall or preset
// R17: stop is data rising while clock high
// R18: stop request generates stop condition
// R19: stop sets flag, interrupt if enabled
// R20: master clocks, slave may stretch low
// R21: waiting party holds clock low
// R22: both lines open drain, low or released
// R23: wait ends on release, write or request
// R24: interrupt and wait at selected fall
// R25: lines synchronised before any detection
module twbc_top #(
  parameter int HALF_CYC = twbc_pkg::SCL_HALF_CYC // scl half period
) (
  input  wire logic        hclk,              // system clock
  input  wire logic        hresetn,           // async reset, low
  input  wire logic        hsel,              // slave select
  input  wire logic [31:0] haddr,             // byte address
  input  wire logic [1:0]  htrans,            // transfer type
  input  wire logic        hwrite,            // write when high
  input  wire logic [2:0]  hsize,             // word only
  input  wire logic [31:0] hwdata,            // write data
  input  wire logic        hready,            // bus ready
  output logic             hreadyout,         // never stalls
  output logic             hresp,             // always okay
  output logic      [31:0] hrdata,            // read data
  input  wire logic        serial_clock_pin,  // clock line level
  output logic             scl_o,             // clock drive value
  output logic             scl_oe_n,          // clock drive, low on
  input  wire logic        serial_data_pin,   // data line level
  output logic             sda_o,             // data drive value
  output logic             sda_oe_n,          // data drive, low on
  output logic             transfer_interrupt // one-cycle event
);

  // ---------------------------------------------------------------
  // line synchronisers and conditions
  // ---------------------------------------------------------------
  logic scl_s, sda_s, scl_rise, scl_fall, sda_rise, sda_fall;

  // pins reach logic only through two flops [R25]
  twbc_sync #(.W(2)) u_sync (
    .hclk    (hclk),
    .hresetn (hresetn),
    .d_in    ({serial_clock_pin, serial_data_pin}),
    .lvl     ({scl_s, sda_s}),
    .rise    ({scl_rise, sda_rise}),
    .fall    ({scl_fall, sda_fall})
  );

  logic start_ev;                             // start condition seen
  logic stop_ev;                              // stop condition seen
  assign start_ev = scl_s & sda_fall;         // [R1]
  assign stop_ev  = scl_s & sda_rise;         // [R17]

  // extension codes have upper nibble all zero or all one
  function automatic logic is_ext(input logic [7:0] b);
    is_ext = (b[7:4] == twbc_pkg::EXT_LO) | (b[7:4] == twbc_pkg::EXT_HI);
  endfunction

  // ---------------------------------------------------------------
  // register state
  // ---------------------------------------------------------------
  twbc_pkg::twbc_ctrl_t ctrl_q;               // bus_control_reg
  twbc_pkg::twbc_stat_t stat;                 // bus_status_reg view
  twbc_pkg::twbc_mst_t  m_state_q;            // master sequencer
  logic [7:0]  sr_q;                          // shift_register
  logic [6:0]  own_q;                         // own_address_reg
  logic        spd_q, std_q, ackd_q, trc_q;   // status flags
  logic        match_q, ext_q, wait_q;        // selection and wait
  logic        addr_q;                        // address byte running
  logic [3:0]  rc_q;                          // scl rises in byte
  logic        irq_q;                         // interrupt pulse
  logic        sda_oe_n_q, scl_oe_n_q;        // pin drive flops
  logic        m_scl_low_q;                   // master pulls clock
  logic        m_stop_q;                      // stop, not restart
  logic [15:0] hc_q;                          // half period timer
  logic        wr_q;                          // write data phase
  logic [5:0]  wa_q;                          // write word index
  logic [31:0] hrdata_q;                      // read data flop

  // ---------------------------------------------------------------
  // bus slave
  // ---------------------------------------------------------------
  logic ap;                                   // address phase taken
  logic wr_ctrl, wr_sr, wr_own;               // data phase strobes
  logic stt_w, spt_w, wrel_w;                 // write-one pulses
  assign ap      = hsel & hready & htrans[1];
  assign wr_ctrl = wr_q & (wa_q == twbc_pkg::REG_CTRL);
  assign wr_sr   = wr_q & (wa_q == twbc_pkg::REG_SHIFT);
  assign wr_own  = wr_q & (wa_q == twbc_pkg::REG_OWN);
  assign stt_w   = wr_ctrl & hwdata[twbc_pkg::CB_STT];
  assign spt_w   = wr_ctrl & hwdata[twbc_pkg::CB_SPT];
  assign wrel_w  = wr_ctrl & hwdata[twbc_pkg::CB_WREL];

  assign stat = '{wait_on: wait_q, match: match_q, ext: ext_q,
                  master: (m_state_q != twbc_pkg::M_IDLE), trc: trc_q,
                  ackd: ackd_q, std: std_q, spd: spd_q};

  // capture the address phase; read data is latched here so the
  // data phase needs no wait state, at the cost of one cycle age
  always_ff @(posedge hclk or negedge hresetn)
    if (!hresetn)
    begin
      wr_q     <= 1'b0;
      wa_q     <= 6'h00;
      hrdata_q <= 32'h0000_0000;
    end
    else
    begin
      wr_q <= ap & hwrite;
      wa_q <= haddr[7:2];
      if (ap & ~hwrite)
      begin
        case (haddr[7:2])
          twbc_pkg::REG_CTRL:  hrdata_q <= {24'h000000, ctrl_q};
          twbc_pkg::REG_STAT:  hrdata_q <= {24'h000000, stat};
          twbc_pkg::REG_SHIFT: hrdata_q <= {24'h000000, sr_q};
          twbc_pkg::REG_OWN:   hrdata_q <= {24'h000000, own_q, 1'b0};
          default:             hrdata_q <= 32'h0000_0000;
        endcase
      end
    end

  assign hreadyout = 1'b1;
  assign hresp     = 1'b0;
  assign hrdata    = hrdata_q;

  // control word: pulse bits are never stored
  always_ff @(posedge hclk or negedge hresetn)
    if (!hresetn)
      ctrl_q <= twbc_pkg::CTRL_RST;
    else if (wr_ctrl)
      ctrl_q <= hwdata[7:0] & 8'h9C;

  // own address sits in bits 7:1
  always_ff @(posedge hclk or negedge hresetn)
    if (!hresetn)
      own_q <= twbc_pkg::OWN_RST;
    else if (wr_own)
      own_q <= hwdata[7:1];

  // ---------------------------------------------------------------
  // byte engine
  // ---------------------------------------------------------------
  logic master_on;                            // sequencer owns bus
  logic en;                                   // block enabled
  logic fall8, fall9;                         // 8th and 9th falls
  logic engaged;                              // part of this transfer
  logic tx_now;                               // this end sends byte
  logic ack_gen;                              // ack to give in slot
  logic am, ae;                               // live address decode
  logic wait_pt;                              // wait and interrupt
  assign master_on = (m_state_q != twbc_pkg::M_IDLE);
  assign en      = ctrl_q.en;
  assign fall8   = scl_fall & (rc_q == twbc_pkg::RC_ACK);
  assign fall9   = scl_fall & (rc_q == twbc_pkg::RC_LAST);
  assign engaged = master_on | addr_q | match_q | ext_q;
  assign am      = (sr_q[7:1] == own_q);      // [R3] [R4]
  assign ae      = is_ext(sr_q);
  // the master sends the address byte, then trc decides
  assign tx_now  = addr_q ? master_on : trc_q;
  // own address always, extension on preset enable, data on
  // the live enable so clearing it refuses the byte
  assign ack_gen = addr_q ? (match_q | (ext_q & ctrl_q.acke)) // [R14] [R15]
                          : ctrl_q.acke;      // [R10] [R12] [R16]

  // wait points follow the selected fall of the clock [R24]
  assign wait_pt = en & (
      (addr_q & master_on & fall9) |
      (addr_q & ~master_on & fall9 & match_q) |  // [R4]
      (addr_q & ~master_on & fall8 & ~am & ae) |
      (~addr_q & (master_on | match_q | ext_q) &
       (ctrl_q.wtim ? fall9 : fall8)));

  // rises counted since start; 9th fall ends the byte
  always_ff @(posedge hclk or negedge hresetn)
    if (!hresetn)
      rc_q <= 4'h0;
    else if (!en | start_ev | fall9)
      rc_q <= 4'h0;
    else if (scl_rise)
      rc_q <= rc_q + 4'h1;

  // shift in the line on the first eight clock rises of a byte, also while sending,
  // so the register always holds what the bus really carried
  always_ff @(posedge hclk or negedge hresetn)
    if (!hresetn)
      sr_q <= twbc_pkg::SHIFT_RST;
    else if (wr_sr)
      sr_q <= hwdata[7:0];                    // [R6]
    else if (scl_rise & (rc_q < twbc_pkg::RC_ACK))
      sr_q <= {sr_q[6:0], sda_s};             // [R6]

  // address byte spans from start to its 9th fall
  always_ff @(posedge hclk or negedge hresetn)
    if (!hresetn)
      addr_q <= 1'b0;
    else if (!en | stop_ev | fall9)
      addr_q <= 1'b0;
    else if (start_ev)
      addr_q <= 1'b1;                         // [R3]

  // slave selection holds until the next start or stop
  always_ff @(posedge hclk or negedge hresetn)
    if (!hresetn)
    begin
      match_q <= 1'b0;
      ext_q   <= 1'b0;
    end
    else if (!en | start_ev | stop_ev)
    begin
      match_q <= 1'b0;
      ext_q   <= 1'b0;
    end
    else if (fall8 & addr_q & ~master_on)
    begin
      match_q <= am;                          // [R4]
      ext_q   <= ~am & ae;
    end

  // direction from the eighth bit: one means the master reads
  always_ff @(posedge hclk or negedge hresetn)
    if (!hresetn)
      trc_q <= 1'b0;
    else if (!en | stop_ev)
      trc_q <= 1'b0;
    else if (fall8 & addr_q)
      trc_q <= master_on ? ~sr_q[0] : sr_q[0]; // [R7] [R11]

  // acknowledge sampled on the ninth rise by the sender
  always_ff @(posedge hclk or negedge hresetn)
    if (!hresetn)
      ackd_q <= 1'b0;
    else if (start_ev)
      ackd_q <= 1'b0;
    else if (scl_rise & (rc_q == twbc_pkg::RC_ACK) & engaged & tx_now)
      ackd_q <= ~sda_s;                       // [R9]

  // start and stop flags replace each other
  always_ff @(posedge hclk or negedge hresetn)
    if (!hresetn)
    begin
      spd_q <= twbc_pkg::SPD_RST;
      std_q <= 1'b0;
    end
    else if (start_ev)
    begin
      spd_q <= 1'b0;
      std_q <= 1'b1;                          // [R2]
    end
    else if (stop_ev)
    begin
      spd_q <= 1'b1;                          // [R19]
      std_q <= 1'b0;
    end

  // wait: a new wait point wins over any release in that cycle
  always_ff @(posedge hclk or negedge hresetn)
    if (!hresetn)
      wait_q <= 1'b0;
    else if (wait_pt)
      wait_q <= 1'b1;                         // [R21]
    else if (m_state_q == twbc_pkg::M_START)
      wait_q <= 1'b1;                         // hold for the address
    else if (!en | start_ev | stop_ev | wrel_w | wr_sr |
             ((m_state_q == twbc_pkg::M_RUN) & (stt_w | spt_w)))
      wait_q <= 1'b0;                         // [R23]

  // transfer event; stop only when its enable is set
  always_ff @(posedge hclk or negedge hresetn)
    if (!hresetn)
      irq_q <= 1'b0;
    else
      irq_q <= wait_pt | (en & stop_ev & ctrl_q.spie); // [R5] [R19]

  assign transfer_interrupt = irq_q;

  // ---------------------------------------------------------------
  // master sequencer
  // ---------------------------------------------------------------
  logic tick;                                 // half period elapsed
  logic hold;                                 // timer kept at zero
  assign tick = (hc_q == 16'(HALF_CYC - 1));
  // released clock counts only once the line is high, which is
  // how a stretching slave slows us down [R20]
  assign hold = (m_state_q == twbc_pkg::M_IDLE) |
                (~m_scl_low_q & ~scl_s) |
                (m_scl_low_q & wait_q & (m_state_q == twbc_pkg::M_RUN));

  always_ff @(posedge hclk or negedge hresetn)
    if (!hresetn)
      hc_q <= 16'h0000;
    else if (hold | tick)
      hc_q <= 16'h0000;
    else
      hc_q <= hc_q + 16'h0001;

  // conditions and clock pulses of the master role
  always_ff @(posedge hclk or negedge hresetn)
    if (!hresetn)
    begin
      m_state_q   <= twbc_pkg::M_IDLE;
      m_scl_low_q <= 1'b0;
      m_stop_q    <= 1'b0;
    end
    else if (!en)
    begin
      m_state_q   <= twbc_pkg::M_IDLE;
      m_scl_low_q <= 1'b0;
      m_stop_q    <= 1'b0;
    end
    else
    begin
      case (m_state_q)
        twbc_pkg::M_IDLE:
          if (stt_w & spd_q)
            m_state_q <= twbc_pkg::M_START;   // [R2]
        twbc_pkg::M_START:
          if (tick)
          begin
            m_state_q   <= twbc_pkg::M_RUN;
            m_scl_low_q <= 1'b1;
          end
        twbc_pkg::M_RUN:
          if (wait_q & (stt_w | spt_w))
          begin
            m_state_q <= twbc_pkg::M_PRE;     // [R13]
            m_stop_q  <= spt_w;               // [R18]
          end
          else if (tick & ~(m_scl_low_q & wait_q))
            m_scl_low_q <= ~m_scl_low_q;      // [R20]
        twbc_pkg::M_PRE:
          if (tick)
          begin
            m_state_q   <= twbc_pkg::M_RISE;
            m_scl_low_q <= 1'b0;
          end
        twbc_pkg::M_RISE:
          if (tick)
            m_state_q <= m_stop_q ? twbc_pkg::M_IDLE
                                  : twbc_pkg::M_START;
        default:
          m_state_q <= twbc_pkg::M_IDLE;
      endcase
    end

  // ---------------------------------------------------------------
  // open-drain pin drive
  // ---------------------------------------------------------------
  logic sda_oe_n_d;                           // next data drive
  logic scl_oe_n_d;                           // next clock drive

  // data may only move while the clock is low, except for the
  // master's own start, restart and stop steps
  always_comb
  begin
    sda_oe_n_d = 1'b1;
    if (!en)
      sda_oe_n_d = 1'b1;
    else if (m_state_q == twbc_pkg::M_START)
      sda_oe_n_d = 1'b0;                      // [R1]
    else if ((m_state_q == twbc_pkg::M_PRE) |
             (m_state_q == twbc_pkg::M_RISE))
      // a stop lets data rise only once the clock stands high;
      // without this release the idle hold would keep it low
      sda_oe_n_d = ~m_stop_q |
                   ((m_state_q == twbc_pkg::M_RISE) & tick); // [R17]
    else if (scl_s)
      sda_oe_n_d = sda_oe_n_q;
    else if (!engaged)
      sda_oe_n_d = 1'b1;
    else if (rc_q < twbc_pkg::RC_ACK)
      sda_oe_n_d = tx_now ? sr_q[7] : 1'b1;   // [R6]
    else if (rc_q == twbc_pkg::RC_ACK)
      sda_oe_n_d = tx_now | ~ack_gen;         // [R8]
  end

  assign scl_oe_n_d = ~(en & (m_scl_low_q | (wait_q & ~master_on)));

  // lines are only pulled low or released [R22]
  always_ff @(posedge hclk or negedge hresetn)
    if (!hresetn)
    begin
      sda_oe_n_q <= 1'b1;
      scl_oe_n_q <= 1'b1;
    end
    else
    begin
      sda_oe_n_q <= sda_oe_n_d;
      scl_oe_n_q <= scl_oe_n_d;               // [R21]
    end

  assign sda_oe_n = sda_oe_n_q;
  assign scl_oe_n = scl_oe_n_q;
  assign sda_o    = 1'b0;
  assign scl_o    = 1'b0;

  // ---------------------------------------------------------------
  // checks
  // ---------------------------------------------------------------
  default clocking cb @(posedge hclk); endclocking
  default disable iff (!hresetn);

  sequence s_ack_slot;
    en && !master_on && addr_q && rc_q == twbc_pkg::RC_ACK && !scl_s;
  endsequence
  sequence s_stop_go;
    en && m_state_q == twbc_pkg::M_RUN && wait_q && spt_w && !stt_w;
  endsequence

  chk_start_flag: assert property (start_ev |=> std_q && !spd_q) // [R2]
    else $error("start not flagged");
  chk_stop_flag: assert property (stop_ev |=> spd_q && !std_q) // [R17]
    else $error("stop not flagged");
  chk_stop_irq: assert property (en && stop_ev && ctrl_q.spie |=> irq_q) // [R19]
    else $error("stop interrupt missing");
  chk_stop_quiet: assert property (stop_ev && !ctrl_q.spie |=> !irq_q) // [R19]
    else $error("stop interrupt while disabled");
  chk_foreign_quiet: assert property (fall8 && addr_q && !master_on && !am && !ae |=> !irq_q) // [R5]
    else $error("interrupt on foreign address");
  chk_own_ack: assert property (s_ack_slot and match_q |=> !sda_oe_n_q) // [R14]
    else $error("own address not acked");
  chk_foreign_nack: assert property (s_ack_slot and !match_q && !ext_q |=> sda_oe_n_q) // [R14]
    else $error("foreign address acked");
  chk_wait_hold: assert property (en && wait_q && !master_on |=> !scl_oe_n_q) // [R21]
    else $error("wait without clock hold");
  chk_wait_rel: assert property (wait_q && wrel_w && !wait_pt && m_state_q != twbc_pkg::M_START |=> !wait_q) // [R23]
    else $error("wait not released");
  chk_trc_load: assert property (fall8 && addr_q && en |=> trc_q == (master_on ^ $past(sr_q[0]))) // [R11]
    else $error("direction flag wrong");
  chk_ack_seen: assert property (scl_rise && rc_q == twbc_pkg::RC_ACK && engaged && tx_now |=> ackd_q == !$past(sda_s)) // [R9]
    else $error("ack flag wrong");
  chk_stop_path: assert property (s_stop_go |=> m_state_q == twbc_pkg::M_PRE && m_stop_q ##1 !scl_oe_n_q) // [R18]
    else $error("stop request not followed");

endmodule // twbc_top

// ### tb/twbc_peer.sv
`timescale 1ns/1ns
// ------------------------------------------
// far-side master: open drain, idles high
// ------------------------------------------
module twbc_peer (
  input  wire logic scl_line, // resolved clock
  input  wire logic sda_line, // resolved data
  output logic      scl_drv,  // 0 pulls low
  output logic      sda_drv   // 0 pulls low
);
  initial
  begin
    scl_drv = 1'b1;
    sda_drv = 1'b1;
  end
  // data moves only while clock low; high half waits out a stretch
  task automatic bitx(input logic b, output logic r);
    #31 sda_drv = b;
    #31 scl_drv = 1'b1;
    wait (scl_line === 1'b1);
    #63 r = sda_line;
    scl_drv = 1'b0;
  endtask
  task automatic start();
    sda_drv = 1'b0;
    #62 scl_drv = 1'b0;
  endtask
  // msb first, ninth slot released to sample the ack
  task automatic xfer(input logic [7:0] d, output logic ack);
    logic r;
    for (int i = 7; i >= 0; i--) bitx(d[i], r);
    bitx(1'b1, ack);
  endtask
  task automatic stop();
    #31 sda_drv = 1'b0;
    #31 scl_drv = 1'b1;
    wait (scl_line === 1'b1);
    #31 sda_drv = 1'b1;
  endtask
endmodule // twbc_peer

// ### tb/tb_two_wire_bus_protocol_ctrl.sv
`timescale 1ns/1ns
module tb_two_wire_bus_protocol_ctrl;
  logic        hclk, hresetn, hsel, hwrite, hreadyout, hresp, irq;
  logic [31:0] haddr, hwdata, hrdata, rd;
  logic [1:0]  htrans;
  logic [2:0]  hsize;
  logic        scl_o, scl_oe_n, sda_o, sda_oe_n, p_scl, p_sda, ack;
  int          n_fail = 0, n_tests = 0, n_irq = 0;
  // wired-and of both parties with pull-ups
  wire scl_w = p_scl & (scl_oe_n | scl_o);
  wire sda_w = p_sda & (sda_oe_n | sda_o);
  twbc_top #(.HALF_CYC(20)) i_dut (.hclk(hclk), .hresetn(hresetn),
    .hsel(hsel), .haddr(haddr), .htrans(htrans), .hwrite(hwrite),
    .hsize(hsize), .hwdata(hwdata), .hready(hreadyout),
    .hreadyout(hreadyout), .hresp(hresp), .hrdata(hrdata),
    .serial_clock_pin(scl_w), .scl_o(scl_o), .scl_oe_n(scl_oe_n),
    .serial_data_pin(sda_w), .sda_o(sda_o), .sda_oe_n(sda_oe_n),
    .transfer_interrupt(irq));
  twbc_peer i_peer (.scl_line(scl_w), .sda_line(sda_w),
    .scl_drv(p_scl), .sda_drv(p_sda));
  initial
  begin
    hclk = 1'b0;
    forever #4 hclk = ~hclk;
  end
  always @(posedge hclk) if (irq === 1'b1) n_irq <= n_irq + 1;
  // one single ahb transfer, read data taken at the closing edge
  task automatic bus(input logic w, input logic [5:0] ix,
                     input logic [31:0] d, output logic [31:0] q);
    @(posedge hclk);
    haddr <= {24'h0, ix, 2'b00};
    htrans <= 2'h2;
    hwrite <= w;
    do @(posedge hclk); while (hreadyout !== 1'b1);
    htrans <= 2'h0;
    hwdata <= d;
    do @(posedge hclk); while (hreadyout !== 1'b1);
    q = hrdata;
  endtask
  task automatic chk(input string nm, input logic [31:0] e, g);
    n_tests++;
    if (g !== e)
    begin
      $display("[ERR] %s exp %h got %h", nm, e, g);
      n_fail++;
    end
  endtask
  // poll a status bit until it reads high
  task automatic poll(input int b);
    do bus(1'b0, twbc_pkg::REG_STAT, 32'h0, rd); while (rd[b] !== 1'b1);
  endtask
  // wait for the wait flag, then end the wait with a control write
  task automatic rel(input logic [31:0] c);
    poll(7);
    bus(1'b1, twbc_pkg::REG_CTRL, c, rd);
  endtask
  task automatic finish_test();
    $display("tests %0d fail %0d", n_tests, n_fail);
    if (n_fail == 0 && n_tests > 0) $display("No errors found");
    else $display("Errors were found");
    $finish;
  endtask
  initial
  begin
    #150000 n_fail++;
    finish_test();
  end
  initial
  begin
    {hresetn, haddr, htrans, hwrite, hwdata} = '0;
    hsel = 1'b1;
    hsize = 3'h2;
    repeat (6) @(posedge hclk);
    hresetn <= 1'b1;
    bus(1'b0, twbc_pkg::REG_STAT, 32'h0, rd);
    chk("status reset", 32'h01, rd);
    bus(1'b1, twbc_pkg::REG_OWN, 32'h54, rd);
    bus(1'b1, twbc_pkg::REG_CTRL, 32'h9C, rd);
    i_peer.start();
    fork i_peer.xfer(8'h54, ack); rel(32'hBC); join
    chk("address ack", 32'h0, ack);
    bus(1'b0, twbc_pkg::REG_STAT, 32'h0, rd);
    chk("status match", 32'h42, rd & 32'h4B);
    fork i_peer.xfer(8'hA5, ack); rel(32'hB0); join
    chk("data ack", 32'h0, ack);
    bus(1'b0, twbc_pkg::REG_SHIFT, 32'h0, rd);
    chk("shift data", 32'hA5, rd);
    fork i_peer.xfer(8'h3C, ack); rel(32'hB0); join
    chk("refused ack", 32'h1, ack);
    i_peer.stop();
    repeat (8) @(posedge hclk);
    bus(1'b0, twbc_pkg::REG_STAT, 32'h0, rd);
    chk("stop flag", 32'h1, rd & 32'h1);
    chk("irq count", 32'h4, n_irq);
    i_peer.start();
    i_peer.xfer(8'h66, ack);
    chk("foreign ack", 32'h1, ack);
    chk("foreign irq", 32'h4, n_irq);
    i_peer.stop();
    repeat (8) @(posedge hclk);
    chk("stop irq", 32'h5, n_irq);
    bus(1'b1, twbc_pkg::REG_CTRL, 32'h94, rd);
    i_peer.start();
    fork i_peer.xfer(8'h00, ack); rel(32'hB4); join
    chk("ext ack", 32'h0, ack);
    bus(1'b0, twbc_pkg::REG_STAT, 32'h0, rd);
    chk("ext flag", 32'h20, rd & 32'h20);
    i_peer.stop();
    poll(0);
    bus(1'b1, twbc_pkg::REG_CTRL, 32'h9E, rd);
    wait (scl_w === 1'b0);
    poll(7);
    bus(1'b1, twbc_pkg::REG_SHIFT, 32'hA0, rd);
    poll(7);
    chk("master status", 32'h9A, rd);
    chk("master irq", 32'h8, n_irq);
    bus(1'b1, twbc_pkg::REG_CTRL, 32'h9D, rd);
    poll(0);
    chk("master stop", 32'h01, rd);
    chk("master stop irq", 32'h9, n_irq);
    finish_test();
  end
endmodule // tb_two_wire_bus_protocol_ctrl
